// ---- include/wdit_pkg.sv ----
// constants for the watchdog interval timer
package wdit_pkg;
  localparam logic [1:0] WDIT_RD_CTRL = 2'h0;
  localparam logic [1:0] WDIT_RD_CNT = 2'h1;
  localparam logic [1:0] WDIT_RD_RST = 2'h3;
  localparam logic [7:0] WDIT_KEY_CNT = 8'h5A;
  localparam logic [7:0] WDIT_KEY_CTRL = 8'hA5;
  localparam logic [7:0] WDIT_CNT_RESET = 8'h00;
  localparam logic [7:0] WDIT_CNT_MAX = 8'hFF;
  localparam int WDIT_OVF_BIT = 7;
  localparam int WDIT_MODE_BIT = 6;
  localparam int WDIT_TME_BIT = 5;
  localparam int WDIT_RESET_ENABLE_BIT_BIT = 6;
  localparam int WDIT_RESET_TYPE_SELECT_BIT = 5;
  localparam logic [7:0] WDIT_CTRL_ONES = 8'h18;
  localparam logic [7:0] WDIT_RST_ONES = 8'h1F;
  localparam int WDIT_CLK_MHZ = 50;
  localparam int WDIT_OUT_CYC = 128;
  localparam int WDIT_RST_CYC = 512;
  localparam int WDIT_PRE_W = 13;
  localparam int WDIT_PULSE_W = 10;
endpackage

// ---- hdl/wdit_top.sv ----
// watchdog and interval timer with keyed register writes
`timescale 1ns/1ns
module wdit_top (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic MANUAL_RESET_PIN_N,
  input wire logic [1:0] ADDR,
  input wire logic RD_EN,
  input wire logic WR_EN,
  input wire logic WR_RST_SEL,
  input wire logic [15:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic STANDBY_REQ,
  input wire logic WAKE_EVENT,
  output logic STANDBY_ACTIVE,
  output logic STANDBY_REFUSED,
  output logic INTERVAL_IRQ,
  output logic OVERFLOW_OUT_N,
  output logic INTERNAL_RESET,
  output logic INTERNAL_RESET_MANUAL
);
  typedef struct packed {
    logic [wdit_pkg::WDIT_PRE_W-1:0] pre;
    logic [7:0] cnt;
    logic ovf;
    logic mode;
    logic timer_enable_bit;
    logic [2:0] cks;
    logic watchdog_overflow_flag;
    logic watchdog_overflow_flag_seen;
    logic reset_enable_bit;
    logic reset_type_select;
    logic [wdit_pkg::WDIT_PULSE_W-1:0] out_cnt;
    logic [wdit_pkg::WDIT_PULSE_W-1:0] rst_cnt;
    logic rst_man;
    logic stby;
    logic [wdit_pkg::WDIT_PULSE_W-1:0] out_len;
    logic [wdit_pkg::WDIT_PULSE_W-1:0] rst_len;
  } wdit_state_t;

  wdit_state_t st_ff, nxt_st;

  function automatic logic tick_sel(input logic [2:0] cks,
                                    input logic [wdit_pkg::WDIT_PRE_W-1:0] p);
    logic [wdit_pkg::WDIT_PRE_W-1:0] m;
    m = '0;
    unique case (cks)
      3'h0: m = 13'h0001;
      3'h1: m = 13'h003F;
      3'h2: m = 13'h007F;
      3'h3: m = 13'h00FF;
      3'h4: m = 13'h01FF;
      3'h5: m = 13'h03FF;
      3'h6: m = 13'h0FFF;
      3'h7: m = 13'h1FFF;
    endcase
    return (p & m) == m;
  endfunction

  logic tick, wrap, wr_cnt, wr_ctrl, ovf_wd, ovf_it;

  always_comb begin
    tick = tick_sel(st_ff.cks, st_ff.pre);
    wrap = (st_ff.timer_enable_bit || st_ff.stby) && tick && st_ff.cnt == wdit_pkg::WDIT_CNT_MAX;
    wr_cnt = WR_EN && !WR_RST_SEL && WDATA[15:8] == wdit_pkg::WDIT_KEY_CNT;
    wr_ctrl = WR_EN && !WR_RST_SEL && WDATA[15:8] == wdit_pkg::WDIT_KEY_CTRL;
    ovf_wd = wrap && st_ff.timer_enable_bit && st_ff.mode;
    ovf_it = wrap && st_ff.timer_enable_bit && !st_ff.mode;
    nxt_st = st_ff;
    nxt_st.pre = st_ff.pre + 1'b1;
    if (st_ff.out_cnt != '0) begin
      nxt_st.out_cnt = st_ff.out_cnt - 1'b1;
    end
    if (st_ff.rst_cnt != '0) begin
      nxt_st.rst_cnt = st_ff.rst_cnt - 1'b1;
    end
    // run lengths of the two pulses, read by the length checks below
    if (!OVERFLOW_OUT_N) begin
      nxt_st.out_len = st_ff.out_len + 1'b1;
    end else begin
      nxt_st.out_len = '0;
    end
    if (INTERNAL_RESET) begin
      nxt_st.rst_len = st_ff.rst_len + 1'b1;
    end else begin
      nxt_st.rst_len = '0;
    end
    if (RD_EN && ADDR == wdit_pkg::WDIT_RD_RST && st_ff.watchdog_overflow_flag) begin
      nxt_st.watchdog_overflow_flag_seen = 1'b1;
    end
    if (!st_ff.timer_enable_bit && !st_ff.stby) begin
      nxt_st.cnt = wdit_pkg::WDIT_CNT_RESET;
    end else if (tick) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
    if (wrap && st_ff.stby) begin
      nxt_st.stby = 1'b0;
    end
    if (STANDBY_REQ && !st_ff.timer_enable_bit) begin
      nxt_st.stby = 1'b1;
    end
    if (st_ff.stby && !WAKE_EVENT && st_ff.cnt == wdit_pkg::WDIT_CNT_RESET && !tick) begin
      nxt_st.stby = st_ff.stby;
    end
    if (wr_cnt) begin
      nxt_st.cnt = WDATA[7:0]; // write wins over increment
    end
    if (wr_ctrl) begin
      nxt_st.mode = WDATA[wdit_pkg::WDIT_MODE_BIT];
      nxt_st.timer_enable_bit = WDATA[wdit_pkg::WDIT_TME_BIT];
      nxt_st.cks = WDATA[2:0];
      if (!WDATA[wdit_pkg::WDIT_OVF_BIT]) begin
        nxt_st.ovf = 1'b0;
      end
      if (!WDATA[wdit_pkg::WDIT_TME_BIT] && !st_ff.mode) begin
        nxt_st.ovf = 1'b0;
      end
    end
    if (WR_EN && WR_RST_SEL) begin
      if (WDATA == {wdit_pkg::WDIT_KEY_CTRL, 8'h00} && st_ff.watchdog_overflow_flag_seen) begin
        nxt_st.watchdog_overflow_flag = 1'b0;
        nxt_st.watchdog_overflow_flag_seen = 1'b0;
      end
      if (WDATA[15:8] == wdit_pkg::WDIT_KEY_CNT) begin
        nxt_st.reset_enable_bit = WDATA[wdit_pkg::WDIT_RESET_ENABLE_BIT_BIT];
        nxt_st.reset_type_select = WDATA[wdit_pkg::WDIT_RESET_TYPE_SELECT_BIT];
      end
    end
    if (ovf_it) begin
      nxt_st.ovf = 1'b1; // set wins over clear
    end
    if (ovf_wd) begin
      nxt_st.watchdog_overflow_flag = 1'b1;
      nxt_st.out_cnt = wdit_pkg::WDIT_PULSE_W'(wdit_pkg::WDIT_OUT_CYC);
      if (st_ff.reset_enable_bit) begin
        nxt_st.rst_cnt = wdit_pkg::WDIT_PULSE_W'(wdit_pkg::WDIT_RST_CYC);
        nxt_st.rst_man = st_ff.reset_type_select;
      end
      nxt_st.cnt = wdit_pkg::WDIT_CNT_RESET;
      nxt_st.ovf = 1'b0;
      nxt_st.mode = 1'b0;
      nxt_st.timer_enable_bit = 1'b0;
      nxt_st.cks = '0;
    end
  end

  // only the external pin resets this flop set; watchdog reset leaves it alone
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_ff <= '0;
    end else if (!MANUAL_RESET_PIN_N) begin
      st_ff <= nxt_st; // pin manual reset keeps counter and control
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    RDATA = 8'h00;
    if (RD_EN) begin
      unique case (ADDR)
        wdit_pkg::WDIT_RD_CTRL: RDATA = {st_ff.ovf, st_ff.mode, st_ff.timer_enable_bit, 2'b00, st_ff.cks}
                                        | wdit_pkg::WDIT_CTRL_ONES;
        wdit_pkg::WDIT_RD_CNT: RDATA = st_ff.cnt;
        wdit_pkg::WDIT_RD_RST: RDATA = {st_ff.watchdog_overflow_flag, st_ff.reset_enable_bit, st_ff.reset_type_select, 5'h00}
                                       | wdit_pkg::WDIT_RST_ONES;
        default: RDATA = 8'h00;
      endcase
    end
  end

  assign INTERVAL_IRQ = st_ff.ovf;
  assign OVERFLOW_OUT_N = !(st_ff.out_cnt != '0);
  assign INTERNAL_RESET = st_ff.rst_cnt != '0;
  assign INTERNAL_RESET_MANUAL = INTERNAL_RESET && st_ff.rst_man;
  assign STANDBY_ACTIVE = st_ff.stby;
  assign STANDBY_REFUSED = STANDBY_REQ && st_ff.timer_enable_bit;

  out_len_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $fell(OVERFLOW_OUT_N) |-> !OVERFLOW_OUT_N [*8])
    else $error("overflow output too short");
  rst_with_out_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $rose(INTERNAL_RESET) |-> $fell(OVERFLOW_OUT_N))
    else $error("internal reset not aligned with overflow output");
  wd_flag_mode_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ovf_it |=> $stable(st_ff.watchdog_overflow_flag) || !st_ff.watchdog_overflow_flag)
    else $error("watchdog flag set in interval mode");
  irq_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ovf_it |=> INTERVAL_IRQ)
    else $error("interval flag not set on overflow");
  hold_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!st_ff.timer_enable_bit && !st_ff.stby && !wr_cnt) |=> st_ff.cnt == wdit_pkg::WDIT_CNT_RESET)
    else $error("counter not held at zero");
  cnt_write_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (wr_cnt && !ovf_wd) |=> st_ff.cnt == $past(WDATA[7:0]))
    else $error("keyed counter write lost");
  wd_reset_ctrl_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    ovf_wd |=> !st_ff.timer_enable_bit && st_ff.cnt == wdit_pkg::WDIT_CNT_RESET && st_ff.watchdog_overflow_flag)
    else $error("watchdog overflow did not reset counter and control");
  standby_refuse_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (STANDBY_REQ && st_ff.timer_enable_bit && !st_ff.stby) |=> !STANDBY_ACTIVE)
    else $error("standby entered while timer enabled");

  // watchdog overflow steps: overflow, then output low with flag set
  sequence wd_ovf_s;
    ovf_wd;
  endsequence

  sequence wd_pulse_start_s;
    ##1 !OVERFLOW_OUT_N && st_ff.watchdog_overflow_flag;
  endsequence

  sequence out_end_s;
    $rose(OVERFLOW_OUT_N);
  endsequence

  wd_steps_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    wd_ovf_s
    |-> wd_pulse_start_s)
    else $error("overflow output or flag missing after overflow");

  out_exact_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    out_end_s
    |-> st_ff.out_len == wdit_pkg::WDIT_PULSE_W'(wdit_pkg::WDIT_OUT_CYC))
    else $error("overflow output length wrong");

  rst_exact_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    $fell(INTERNAL_RESET)
    |-> st_ff.rst_len == wdit_pkg::WDIT_PULSE_W'(wdit_pkg::WDIT_RST_CYC))
    else $error("internal reset length wrong");

  rst_type_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (ovf_wd && st_ff.reset_enable_bit)
    |=> INTERNAL_RESET && INTERNAL_RESET_MANUAL == $past(st_ff.reset_type_select))
    else $error("internal reset type wrong");

  rst_off_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (ovf_wd && !st_ff.reset_enable_bit && !INTERNAL_RESET)
    |=> !INTERNAL_RESET)
    else $error("internal reset issued while disabled");

  watchdog_overflow_flag_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (st_ff.watchdog_overflow_flag && !st_ff.watchdog_overflow_flag_seen)
    |=> st_ff.watchdog_overflow_flag)
    else $error("watchdog flag cleared without prior read");

  watchdog_overflow_flag_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (WR_EN && WR_RST_SEL && WDATA == {wdit_pkg::WDIT_KEY_CTRL, 8'h00} && st_ff.watchdog_overflow_flag_seen && !ovf_wd)
    |=> !st_ff.watchdog_overflow_flag)
    else $error("watchdog flag clear lost");

  watchdog_overflow_flag_noset_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!st_ff.watchdog_overflow_flag && !ovf_wd)
    |=> !st_ff.watchdog_overflow_flag)
    else $error("watchdog flag set without watchdog overflow");

  reset_enable_bit_load_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (WR_EN && WR_RST_SEL && WDATA[15:8] == wdit_pkg::WDIT_KEY_CNT)
    |=> st_ff.reset_enable_bit == $past(WDATA[wdit_pkg::WDIT_RESET_ENABLE_BIT_BIT]))
    else $error("reset enable load lost");

  ctrl_load_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (wr_ctrl && !ovf_wd)
    |=> st_ff.cks == $past(WDATA[2:0]))
    else $error("keyed control write lost");

  irq_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (st_ff.ovf && !wr_ctrl && !ovf_wd)
    |=> INTERVAL_IRQ)
    else $error("interval interrupt dropped while flag set");

  tme_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (wr_ctrl && !WDATA[wdit_pkg::WDIT_TME_BIT] && !st_ff.mode && !ovf_it)
    |=> !INTERVAL_IRQ)
    else $error("interval flag not cleared by timer disable");

  pin_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (!MANUAL_RESET_PIN_N && !wr_ctrl && !ovf_wd)
    |=> st_ff.mode == $past(st_ff.mode) && st_ff.timer_enable_bit == $past(st_ff.timer_enable_bit))
    else $error("manual reset pin changed control");

  stby_exit_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (wrap && st_ff.stby && !STANDBY_REQ)
    |=> !STANDBY_ACTIVE)
    else $error("standby not ended on counter wrap");

  tick_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (tick && !wr_ctrl)
    |=> !tick)
    else $error("count enable longer than one cycle");

  cnt_step_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (st_ff.timer_enable_bit && tick && !wr_cnt && !ovf_wd)
    |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01)
    else $error("counter did not advance on count enable");

  ctrl_ones_a: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
    (RD_EN && ADDR == wdit_pkg::WDIT_RD_CTRL)
    |-> (RDATA & wdit_pkg::WDIT_CTRL_ONES) == wdit_pkg::WDIT_CTRL_ONES)
    else $error("reserved control bits not read as one");
endmodule

// ---- tb/wdit_cpu_model.sv ----
// processor core model issuing keyed word writes and byte reads
`timescale 1ns/1ns
module wdit_cpu_model (
  input wire logic CLK_SYS,
  input wire logic [7:0] RDATA,
  output logic [1:0] ADDR,
  output logic RD_EN,
  output logic WR_EN,
  output logic WR_RST_SEL,
  output logic [15:0] WDATA
);
  initial begin
    ADDR = 2'h2;
    RD_EN = 1'b0;
    WR_EN = 1'b0;
    WR_RST_SEL = 1'b0;
    WDATA = 16'h0000;
  end
  // whole 16-bit word, key in upper byte
  task automatic wr(input logic sel, input logic [15:0] w);
    @(negedge CLK_SYS);
    WR_EN = 1'b1;
    WR_RST_SEL = sel;
    WDATA = w;
    @(negedge CLK_SYS);
    WR_EN = 1'b0;
    WDATA = ~w;
  endtask
  // byte read, data taken at the rising edge
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(negedge CLK_SYS);
    RD_EN = 1'b1;
    ADDR = a;
    @(posedge CLK_SYS);
    d = RDATA;
    @(negedge CLK_SYS);
    RD_EN = 1'b0;
    ADDR = ~a;
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ns
module testbench;
  logic CLK_SYS, RSTN, MANUAL_RESET_PIN_N, STANDBY_REQ, WAKE_EVENT;
  logic [1:0] ADDR;
  logic RD_EN, WR_EN, WR_RST_SEL;
  logic [15:0] WDATA;
  logic [7:0] RDATA, d;
  logic STANDBY_ACTIVE, STANDBY_REFUSED, INTERVAL_IRQ, OVERFLOW_OUT_N;
  logic INTERNAL_RESET, INTERNAL_RESET_MANUAL;
  int n_errors = 0;
  int check_count = 0;
  int n_lo, n_hi;
  wdit_top wdit_top_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .MANUAL_RESET_PIN_N(MANUAL_RESET_PIN_N), .ADDR(ADDR), .RD_EN(RD_EN), .WR_EN(WR_EN),
    .WR_RST_SEL(WR_RST_SEL), .WDATA(WDATA), .RDATA(RDATA), .STANDBY_REQ(STANDBY_REQ),
    .WAKE_EVENT(WAKE_EVENT), .STANDBY_ACTIVE(STANDBY_ACTIVE),
    .STANDBY_REFUSED(STANDBY_REFUSED), .INTERVAL_IRQ(INTERVAL_IRQ),
    .OVERFLOW_OUT_N(OVERFLOW_OUT_N), .INTERNAL_RESET(INTERNAL_RESET),
    .INTERNAL_RESET_MANUAL(INTERNAL_RESET_MANUAL));
  wdit_cpu_model wdit_cpu_model_inst (.CLK_SYS(CLK_SYS), .RDATA(RDATA), .ADDR(ADDR),
    .RD_EN(RD_EN), .WR_EN(WR_EN), .WR_RST_SEL(WR_RST_SEL), .WDATA(WDATA));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string nm);
    wdit_cpu_model_inst.rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    RSTN = 1'b0;
    MANUAL_RESET_PIN_N = 1'b1;
    STANDBY_REQ = 1'b0;
    WAKE_EVENT = 1'b0;
    repeat (12) @(negedge CLK_SYS);
    RSTN = 1'b1;
    rdc(2'h0, 8'h18, "ctrl");
    rdc(2'h3, 8'h1F, "rstc");
    rdc(2'h1, 8'h00, "cnt");
    // interval mode, divide by 2: 512 cycles to overflow
    wdit_cpu_model_inst.wr(1'b0, 16'hA538);
    n_lo = 0;
    while (INTERVAL_IRQ !== 1'b1 && n_lo < 600) begin
      @(negedge CLK_SYS);
      n_lo++;
    end
    chk("irq_time", 16'd512, n_lo[15:0]);
    rdc(2'h0, 8'hB8, "ovf");
    rdc(2'h3, 8'h1F, "no_watchdog_overflow_flag");
    STANDBY_REQ = 1'b1;
    @(negedge CLK_SYS);
    chk("refused", 16'h0001, {15'h0, STANDBY_REFUSED});
    STANDBY_REQ = 1'b0;
    MANUAL_RESET_PIN_N = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    MANUAL_RESET_PIN_N = 1'b1;
    rdc(2'h0, 8'hB8, "manual_reset_pin_n_keep");
    wdit_cpu_model_inst.wr(1'b0, 16'hA518);
    @(negedge CLK_SYS);
    chk("irq_clr", 16'h0000, {15'h0, INTERVAL_IRQ});
    rdc(2'h1, 8'h00, "cnt_hold");
    // watchdog mode with manual internal reset
    wdit_cpu_model_inst.wr(1'b1, 16'h5A60);
    rdc(2'h3, 8'h7F, "reset_enable_bit_reset_type_select");
    wdit_cpu_model_inst.wr(1'b0, 16'hA578);
    wdit_cpu_model_inst.wr(1'b0, 16'h5AFE);
    n_lo = 0;
    n_hi = 0;
    repeat (700) begin
      @(negedge CLK_SYS);
      n_lo += (OVERFLOW_OUT_N === 1'b0);
      n_hi += (INTERNAL_RESET === 1'b1 && INTERNAL_RESET_MANUAL === 1'b1);
    end
    chk("ovf_out_len", 16'd128, n_lo[15:0]);
    chk("int_rst_len", 16'd512, n_hi[15:0]);
    rdc(2'h3, 8'hFF, "watchdog_overflow_flag");
    rdc(2'h0, 8'h18, "ctrl_wdrst");
    wdit_cpu_model_inst.wr(1'b1, 16'hA5FF);
    rdc(2'h3, 8'hFF, "watchdog_overflow_flag_w1");
    wdit_cpu_model_inst.wr(1'b1, 16'hA500);
    rdc(2'h3, 8'h7F, "watchdog_overflow_flag_clr");
    // watchdog mode with power-on internal reset, then standby
    wdit_cpu_model_inst.wr(1'b1, 16'h5A40);
    wdit_cpu_model_inst.wr(1'b0, 16'hA578);
    wdit_cpu_model_inst.wr(1'b0, 16'h5AFE);
    n_lo = 0;
    n_hi = 0;
    repeat (700) begin
      @(negedge CLK_SYS);
      n_lo += (INTERNAL_RESET === 1'b1);
      n_hi += (INTERNAL_RESET_MANUAL === 1'b1);
    end
    chk("por_rst_len", 16'd512, n_lo[15:0]);
    chk("por_manual", 16'd0, n_hi[15:0]);
    STANDBY_REQ = 1'b1;
    @(negedge CLK_SYS);
    STANDBY_REQ = 1'b0;
    chk("stby_in", 16'h0001, {15'h0, STANDBY_ACTIVE});
    repeat (500) @(negedge CLK_SYS);
    chk("stby_wait", 16'h0001, {15'h0, STANDBY_ACTIVE});
    repeat (20) @(negedge CLK_SYS);
    chk("stby_out", 16'h0000, {15'h0, STANDBY_ACTIVE});
    tally_and_finish();
  end
endmodule
